// File: hw/plei_pkg.sv
package plei_pkg;
	// ==========================================================
	// Register map (index = word number, byte address = 4 * index)
	// ==========================================================
	localparam logic [5:0] IDX_CTRL = 6'h11;
	localparam logic [5:0] IDX_LINK_EVENT = 6'h12;
	localparam int ADDR_LSB = 2;
	localparam int REG_W = 16;
	localparam int ADDR_MSB = 7;
	localparam int LANE_CFG = 0;
	localparam int LANE_PEND = 1;

	// ==========================================================
	// Event register layout: pending at EVT_BASE+n, enable at n
	// ==========================================================
	localparam int N_EVT = 8;
	localparam int EVT_BASE = 8;
	localparam int EV_RXERR_HF = 0;
	localparam int EV_FCAR_HF = 1;
	localparam int EV_AN_DONE = 2;
	localparam int EV_DUPLEX = 3;
	localparam int EV_SPEED = 4;
	localparam int EV_LINK = 5;
	localparam int EV_ENERGY = 6;
	localparam int EV_QUALITY = 7;
	localparam logic [N_EVT-1:0] EVT_RESET = 8'h00;

	// ==========================================================
	// Control register layout
	// ==========================================================
	localparam int CTL_OUT_EN = 0;
	localparam int CTL_GLOBAL_EN = 1;
	localparam int CTL_TEST = 2;
	localparam int CTL_POLARITY = 3;
	localparam int CTL_W = 4;
	localparam logic [CTL_W-1:0] CTL_RESET = 4'h8;

	// ==========================================================
	// Counter thresholds
	// ==========================================================
	localparam int FC_CNT_W = 8;
	localparam logic [FC_CNT_W-1:0] FC_HALF = 8'h7f;
	localparam int RX_CNT_W = 16;
	localparam logic [RX_CNT_W-1:0] RX_HALF = 16'h7fff;
	localparam int SPEED_W = 2;

	// ==========================================================
	// Bus handshake states
	// ==========================================================
	typedef enum logic [1:0] {
		PLEI_IDLE = 2'b01,
		PLEI_ACK = 2'b10
	} plei_bus_state_t;
endpackage

// File: hw/plei_top.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// RULE1 - Bit 15 sets on link quality change while link up; read clears.
// RULE2 - Bit 14 sets on any energy detect change; read clears.
// RULE3 - Bit 13 sets on link status change; pending until read.
// RULE4 - Bit 12 sets on speed status change; read clears.
// RULE5 - Bit 11 sets on duplex status change; read clears.
// RULE6 - Bit 10 sets when auto-negotiation completes; read clears.
// RULE7 - Bit 9 sets when false carrier count passes half range; read clears.
// RULE8 - Bit 8 sets when receive error count passes half range; read clears.
// RULE9 - Enable bits 7..4 for quality, energy, link, speed; reset zero.
// RULE10 - Enable bit 3 duplex, bit 2 auto-negotiation; reset zero.
// RULE11 - Enable bit 1 false carrier, bit 0 receive error; reset zero.
// RULE12 - Event interrupts need the global enable in the control register.
// RULE13 - Polarity bit set: pin idles high, low on interrupt; else inverted.
// RULE14 - Test bit forces an interrupt for as long as it stays set.
// RULE15 - False carrier count above 7Fh counts as half full.
// RULE16 - Pending bits latch regardless of enable; request is pending and enable.
// RULE17 - Read clears pending atomically; same-cycle events stay pending.
module plei_top (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_link_up,
	input wire logic i_link_quality_good,
	input wire logic i_energy_detect,
	input wire logic [plei_pkg::SPEED_W-1:0] i_speed,
	input wire logic i_full_duplex,
	input wire logic i_an_complete,
	input wire logic [plei_pkg::FC_CNT_W-1:0] i_false_carrier_count,
	input wire logic [plei_pkg::RX_CNT_W-1:0] i_rx_error_count,
	output logic o_irq,
	output logic o_int_pin,
	output logic o_int_pin_oe
);

	// ==========================================================
	// Avalon-MM slave: one wait state per access
	// ==========================================================
	plei_pkg::plei_bus_state_t bus_state;
	logic req;
	logic accept;
	logic [5:0] index;
	logic hit_ctrl;
	logic hit_evt;

	// Waitrequest is combinational, so the second cycle of a request is the ack
	assign req = i_avs_read | i_avs_write;
	assign accept = req && (bus_state == plei_pkg::PLEI_ACK);
	assign o_avs_waitrequest = req && (bus_state != plei_pkg::PLEI_ACK);
	assign index = i_avs_address[plei_pkg::ADDR_MSB:plei_pkg::ADDR_LSB];

	always_comb begin
		hit_ctrl = 1'b0;
		hit_evt = 1'b0;
		if (index == plei_pkg::IDX_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (index == plei_pkg::IDX_LINK_EVENT) begin
			hit_evt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bus_state <= plei_pkg::PLEI_IDLE;
		end else begin
			case (bus_state)
				plei_pkg::PLEI_IDLE: begin
					if (req) begin
						bus_state <= plei_pkg::PLEI_ACK;
					end
				end
				plei_pkg::PLEI_ACK: begin
					bus_state <= plei_pkg::PLEI_IDLE;
				end
				default: begin
					bus_state <= plei_pkg::PLEI_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Event detection
	// ==========================================================
	logic prev_link_up;
	logic prev_quality;
	logic prev_energy;
	logic [plei_pkg::SPEED_W-1:0] prev_speed;
	logic prev_duplex;
	logic prev_an;
	logic prev_fc_half;
	logic prev_rx_half;
	logic fc_half;
	logic rx_half;
	logic [plei_pkg::N_EVT-1:0] events;

	// Half-full fires once on the upward crossing; a count parked above does not retrigger
	assign fc_half = i_false_carrier_count > plei_pkg::FC_HALF; // RULE15
	assign rx_half = i_rx_error_count > plei_pkg::RX_HALF;

	// History resets to link-down levels; a status already up at release
	// reports one change, which software wants to see anyway.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_link_up <= 1'b0;
		end else begin
			prev_link_up <= i_link_up;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_quality <= 1'b0;
		end else begin
			prev_quality <= i_link_quality_good;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_energy <= 1'b0;
		end else begin
			prev_energy <= i_energy_detect;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_speed <= '0;
		end else begin
			prev_speed <= i_speed;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_duplex <= 1'b0;
		end else begin
			prev_duplex <= i_full_duplex;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_an <= 1'b0;
		end else begin
			prev_an <= i_an_complete;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_fc_half <= 1'b0;
		end else begin
			prev_fc_half <= fc_half;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_rx_half <= 1'b0;
		end else begin
			prev_rx_half <= rx_half;
		end
	end

	always_comb begin
		events = '0;
		events[plei_pkg::EV_QUALITY] = i_link_up && (i_link_quality_good != prev_quality); // RULE1
		events[plei_pkg::EV_ENERGY] = i_energy_detect != prev_energy; // RULE2
		events[plei_pkg::EV_LINK] = i_link_up != prev_link_up; // RULE3
		events[plei_pkg::EV_SPEED] = i_speed != prev_speed; // RULE4
		events[plei_pkg::EV_DUPLEX] = i_full_duplex != prev_duplex; // RULE5
		events[plei_pkg::EV_AN_DONE] = i_an_complete && !prev_an; // RULE6
		events[plei_pkg::EV_FCAR_HF] = fc_half && !prev_fc_half; // RULE7
		events[plei_pkg::EV_RXERR_HF] = rx_half && !prev_rx_half; // RULE8
	end

	// ==========================================================
	// Registers
	// ==========================================================
	logic [plei_pkg::N_EVT-1:0] pending;
	logic [plei_pkg::N_EVT-1:0] enable;
	logic [plei_pkg::CTL_W-1:0] ctrl;
	logic [plei_pkg::N_EVT-1:0] clr_mask;
	logic [31:0] next_readdata;
	logic wr_accept;
	logic rd_capture;
	logic wr_evt;
	logic rd_evt;
	logic wr_enable;
	logic wr_pending;
	logic wr_ctrl;

	assign wr_accept = accept && i_avs_write;
	assign rd_capture = i_avs_read && (bus_state == plei_pkg::PLEI_IDLE);
	assign wr_evt = wr_accept && hit_evt;
	assign rd_evt = accept && i_avs_read && hit_evt;
	assign wr_enable = wr_evt && i_avs_byteenable[plei_pkg::LANE_CFG];
	assign wr_pending = wr_evt && i_avs_byteenable[plei_pkg::LANE_PEND];
	assign wr_ctrl = wr_accept && hit_ctrl && i_avs_byteenable[plei_pkg::LANE_CFG];

	// Only the bits actually returned to software (captured one edge earlier)
	// are cleared, so an event landing during the access survives.
	always_comb begin
		clr_mask = '0;
		if (rd_evt) begin
			clr_mask = o_avs_readdata[plei_pkg::EVT_BASE +: plei_pkg::N_EVT]; // RULE17
		end else if (wr_pending) begin
			clr_mask = i_avs_writedata[plei_pkg::EVT_BASE +: plei_pkg::N_EVT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pending <= plei_pkg::EVT_RESET;
		end else begin
			pending <= (pending & ~clr_mask) | events; // RULE16 RULE17
		end
	end

	// Enables gate only the request; pending bits latch regardless
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			enable <= plei_pkg::EVT_RESET; // RULE9 RULE10 RULE11
		end else if (wr_enable) begin
			enable <= i_avs_writedata[plei_pkg::N_EVT-1:0]; // RULE9 RULE10 RULE11
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl <= plei_pkg::CTL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= i_avs_writedata[plei_pkg::CTL_W-1:0];
		end
	end

	// Unused upper bits and unmapped words read as zero
	always_comb begin
		next_readdata = '0;
		if (hit_evt) begin
			next_readdata[plei_pkg::EVT_BASE +: plei_pkg::N_EVT] = pending;
			next_readdata[plei_pkg::N_EVT-1:0] = enable;
		end else if (hit_ctrl) begin
			next_readdata[plei_pkg::CTL_W-1:0] = ctrl;
		end
	end

	// Read data is captured on the first request edge and held for the ack
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_avs_readdata <= '0;
		end else if (rd_capture) begin
			o_avs_readdata <= next_readdata;
		end
	end

	// ==========================================================
	// Interrupt output
	// ==========================================================
	logic event_irq;
	logic test_irq;
	logic irq_now;
	logic next_pin;

	assign event_irq = ctrl[plei_pkg::CTL_GLOBAL_EN] && |(pending & enable); // RULE12 RULE16
	assign test_irq = ctrl[plei_pkg::CTL_TEST]; // RULE14
	assign irq_now = event_irq || test_irq;
	assign next_pin = irq_now ^ ctrl[plei_pkg::CTL_POLARITY]; // RULE13

	// Registered so the pin cannot glitch while several sources change together
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_now;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_int_pin <= plei_pkg::CTL_RESET[plei_pkg::CTL_POLARITY];
		end else begin
			o_int_pin <= next_pin; // RULE13
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_int_pin_oe <= 1'b0;
		end else begin
			o_int_pin_oe <= ctrl[plei_pkg::CTL_OUT_EN];
		end
	end

endmodule

// File: test/plei_monitor.sv
`timescale 1ns/1ps
module plei_monitor (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_irq,
	input wire logic o_int_pin
);
	logic req;
	logic take;
	assign req = i_avs_read || i_avs_write;
	assign take = i_avs_read && !o_avs_waitrequest;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// ==========================================================
	// Bus handshake, read data and interrupt request and pin
	// ==========================================================
	sequence s_first;
		req && o_avs_waitrequest;
	endsequence
	// A polarity write can move the pin without the request moving
	sequence s_no_wr;
		!$past(i_avs_write) && !$past(i_avs_write, 2);
	endsequence
	a_wait_first: assert property ($rose(i_avs_read) |-> o_avs_waitrequest) else $error("no wait");
	a_wait_single: assert property (s_first |=> !o_avs_waitrequest) else $error("long wait");
	a_wait_idle: assert property (!req |-> !o_avs_waitrequest) else $error("idle wait");
	a_upper_zero: assert property (take |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("upper bits set");
	a_unmapped_zero: assert property (take && i_avs_address[7:2] != plei_pkg::IDX_CTRL
		&& i_avs_address[7:2] != plei_pkg::IDX_LINK_EVENT |-> o_avs_readdata == 32'h0)
		else $error("unmapped data");
	a_ctrl_width: assert property (take && i_avs_address[7:2] == plei_pkg::IDX_CTRL
		|-> o_avs_readdata[31:4] == 28'h0) else $error("ctrl width");
	a_pin_follow: assert property ($changed(o_irq) ##0 s_no_wr |-> $changed(o_int_pin))
		else $error("pin lost request");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(req) || $past(req, 2))
		else $error("request dropped alone");
endmodule
bind plei_top plei_monitor u_mon (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_irq(o_irq), .o_int_pin(o_int_pin));

// File: test/plei_top_tb.sv
`timescale 1ns/1ps
module plei_top_tb;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'h0;
	logic lu = 1'b0, lq = 1'b0, ed = 1'b0, fd = 1'b0, an = 1'b0;
	logic [1:0] sp = 2'h0;
	logic [7:0] fc = 8'h00;
	logic [15:0] rx = 16'h0000;
	logic [31:0] rdata, q;
	logic wreq, irq, pin, oe;
	int err_count = 0;
	int checked = 0;
	logic [15:0] row_exp [8] = '{16'h01ff, 16'h02ff, 16'h04ff, 16'h08ff,
		16'h10ff, 16'h20ff, 16'h40ff, 16'h80ff};
	always #5 i_core_clk = ~i_core_clk;
	plei_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_avs_address(adr),
		.i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
		.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_link_up(lu), .i_link_quality_good(lq), .i_energy_detect(ed), .i_speed(sp),
		.i_full_duplex(fd), .i_an_complete(an), .i_false_carrier_count(fc),
		.i_rx_error_count(rx), .o_irq(irq), .o_int_pin(pin), .o_int_pin_oe(oe));
	// ==========================================================
	// Checking and bus tasks
	// ==========================================================
	task automatic complete_run;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Pending bits need one edge, the request and pin one more
	task automatic settle(input logic [2:0] e);
		repeat (4) @(posedge i_core_clk);
		chk({29'h0, irq, pin, oe}, {29'h0, e});
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge i_core_clk);
		adr <= a;
		rd_en <= !w;
		wr_en <= w;
		wdat <= d;
		be <= b;
		do begin
			@(posedge i_core_clk);
		end while (wreq !== 1'b0);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 4'hf);
		chk(q, e);
	endtask
	task automatic evt(input int n);
		@(posedge i_core_clk);
		case (n)
			0: rx <= 16'h8000;
			1: fc <= 8'h80;
			2: an <= 1'b1;
			3: fd <= ~fd;
			4: sp <= sp + 2'h1;
			5: lu <= ~lu;
			6: ed <= ~ed;
			default: lq <= ~lq;
		endcase
	endtask
	initial begin
		repeat (20000) @(posedge i_core_clk);
		err_count++;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		settle(3'b010);
		rd(8'h48, 32'h0);
		rd(8'h44, 32'h8);
		xfer(1'b1, 8'h40, 32'hffff, 4'hf);
		rd(8'h40, 32'h0);
		xfer(1'b1, 8'h44, 32'hb, 4'h1);
		xfer(1'b1, 8'h48, 32'hff, 4'h1);
		fc <= 8'h7f;
		rx <= 16'h7fff;
		settle(3'b011);
		rd(8'h48, 32'hff);
		// Row n drives event n; the link comes up before the quality row
		for (int n = 0; n < 8; n++) begin
			evt(n);
			settle(3'b101);
			rd(8'h48, {16'h0000, row_exp[n]});
			rd(8'h48, 32'hff);
			settle(3'b011);
		end
		xfer(1'b1, 8'h48, 32'h0, 4'h1);
		evt(6);
		settle(3'b011);
		xfer(1'b1, 8'h48, 32'h40, 4'h1);
		settle(3'b101);
		xfer(1'b1, 8'h44, 32'h9, 4'h1);
		settle(3'b011);
		rd(8'h48, 32'h4040);
		xfer(1'b1, 8'h44, 32'hd, 4'h1);
		settle(3'b101);
		xfer(1'b1, 8'h44, 32'h5, 4'h1);
		settle(3'b111);
		xfer(1'b1, 8'h44, 32'h1, 4'h1);
		settle(3'b001);
		// An event landing on the clearing edge of a read must stay pending
		fork
			xfer(1'b0, 8'h48, 32'h0, 4'hf);
			begin
				repeat (2) @(posedge i_core_clk);
				ed <= ~ed;
			end
		join
		chk(q, 32'h40);
		rd(8'h48, 32'h4040);
		// Write-one-to-clear on lane 1 leaves the enables alone
		xfer(1'b1, 8'h44, 32'h3, 4'h1);
		evt(6);
		settle(3'b111);
		xfer(1'b1, 8'h48, 32'h4000, 4'h2);
		settle(3'b001);
		rd(8'h48, 32'h40);
		// Reset in mid-run returns every register to its reset value
		lu <= 1'b0;
		lq <= 1'b0;
		ed <= 1'b0;
		fd <= 1'b0;
		an <= 1'b0;
		sp <= 2'h0;
		fc <= 8'h00;
		rx <= 16'h0000;
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		settle(3'b010);
		rd(8'h48, 32'h0);
		rd(8'h44, 32'h8);
		complete_run;
	end
endmodule
